// ---- logic/ramp_ctrl_pkg.sv ----
// Functional notes
// R01: Three-state bit floats charge pump; counter reset bit holds RF counters.
// R02: Low three word bits route to function, clock, deviation, step or delay register.
// R03: Strobe sync select retimes the load strobe to the phase detector clock.
// R04: Integer mode code disables modulator and ramping; host zeroes fractions.
// R05: Ramp status picks readback, ramp-complete pulse, or forced pump up/down.
// R06: Host sets the multiplexed output select to all ones for those options.
// R07: Clock divider mode runs timer as ramp counter, fast lock, or off.
// R08: Ramp timer sets step timeout in ramp mode, wideband time in fast lock.
// R09: Divider select loads the step-time divider (0) or the ramp timer (1).
// R10: Trigger invert picks rising (0) or falling (1) active trigger edge.
// R11: Ramp clock source is the internal divider (0) or trigger pin edges (1).
// R12: Parabolic bit makes steps grow each step; otherwise a linear ramp.
// R13: Trigger rising edge captures frequency for readback; sweep goes or stops.
// R14: FSK ramp adds deviation while trigger high; dual ramp alternates sets.
// R15: Deviation select writes word one or two, each with shift and step.
// R16: Step select writes step word one or two; it counts steps per ramp.
// R17: Trigger-started ramp waits the start delay only with both delay bits.
// R18: Triangular delay pauses between sections; single triangle runs once.
// R19: Trigger enable lets a high trigger level start the ramp.
// R20: Fast ramp returns from top to bottom in small steps.
// R21: Ramp delay pauses between ramps; delay fast lock widens loop meanwhile.
// R22: Delay clock is phase detector tick or that times the step divider.
// R23: Host programs delay down to function, select-bit registers twice.
// R24: Host writes all reserved bits as zero.
package ramp_ctrl_pkg;
  localparam logic [2:0] ADDR_FUNC = 3'h3;
  localparam logic [2:0] ADDR_CLK  = 3'h4;
  localparam logic [2:0] ADDR_DEV  = 3'h5;
  localparam logic [2:0] ADDR_STEP = 3'h6;
  localparam logic [2:0] ADDR_DLY  = 3'h7;
  localparam int FN_TRI = 4;
  localparam int FN_CRST = 3;
  localparam int CK_SYNC = 31;
  localparam int CK_SEL = 6;
  localparam int DV_INV = 30;
  localparam int DV_TXCLK = 29;
  localparam int DV_PARAB = 28;
  localparam int DV_FSKR = 25;
  localparam int DV_DUAL = 24;
  localparam int SEL_BIT = 23;
  localparam int DL_TRIG_DLY = 23;
  localparam int DL_TRI_DLY = 22;
  localparam int DL_SINGLE = 21;
  localparam int DL_TRIG_EN = 20;
  localparam int DL_FAST = 19;
  localparam int DL_FL = 18;
  localparam int DL_RAMP_DLY = 17;
  localparam int DL_CLKSEL = 16;
  localparam int DL_DSTART = 15;
  localparam logic [4:0] SD_NORMAL  = 5'h00;
  localparam logic [4:0] SD_INTEGER = 5'h0E;
  localparam logic [4:0] ST_READBACK = 5'h02;
  localparam logic [4:0] ST_DONE     = 5'h03;
  localparam logic [4:0] ST_CP_UP    = 5'h10;
  localparam logic [4:0] ST_CP_DOWN  = 5'h11;
  localparam logic [1:0] CDM_OFF  = 2'h0;
  localparam logic [1:0] CDM_FL   = 2'h1;
  localparam logic [1:0] CDM_RAMP = 2'h3;
  localparam logic [1:0] IRQ_OFF  = 2'h0;
  localparam logic [1:0] IRQ_STOP = 2'h3;

  typedef struct packed {
    logic        cp3;
    logic        crst;
    logic        sync_sel;
    logic [4:0]  sd_mode;
    logic [4:0]  status;
    logic [1:0]  cdm;
    logic [11:0] clk1;
    logic [11:0] clk2;
    logic [30:24] dvf;
    logic [3:0]  sh0;
    logic [3:0]  sh1;
    logic [15:0] dev0;
    logic [15:0] dev1;
    logic [19:0] st0;
    logic [19:0] st1;
    logic [23:3] dly;
  } cfg_t;

  localparam cfg_t CFG_RST = '0;

  typedef enum logic [2:0] {IDLE, SDLY, RUN, GAP, HOLD} ramp_state_t;
endpackage : ramp_ctrl_pkg

// ---- logic/serial_word_if.sv ----
`timescale 1ns/1ps
interface serial_word_if;
  logic [31:0] word;
  logic        load;
  modport src (output word, output load);
  modport dst (input word, input load);
endinterface : serial_word_if

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1, s2, s3, next_level;
  always_comb begin
    next_level = (s2 == s3) ? s3 : level_out;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level_out <= next_level;
    end
  end
endmodule : pin_sync

// ---- logic/serial_port.sv ----
`timescale 1ns/1ps
module serial_port (
  input  wire logic     clk_in,
  input  wire logic     rst_in,
  input  wire logic     sclk_in,
  input  wire logic     sdata_in,
  input  wire logic     strobe_in,
  serial_word_if.src    out
);
  logic [31:0] shift, next_shift, word, next_word;
  logic        sclk_d, strobe_d, load, next_load;
  always_comb begin
    next_shift = shift;
    next_word = word;
    next_load = 1'b0;
    if (sclk_in && !sclk_d) begin
      next_shift = {shift[30:0], sdata_in};
    end
    if (strobe_in && !strobe_d) begin
      next_word = shift;
      next_load = 1'b1;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift <= 32'h0000_0000;
      word <= 32'h0000_0000;
      load <= 1'b0;
      sclk_d <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      shift <= next_shift;
      word <= next_word;
      load <= next_load;
      sclk_d <= sclk_in;
      strobe_d <= strobe_in;
    end
  end
  assign out.word = word;
  assign out.load = load;
endmodule : serial_port

// ---- logic/ramp_waveform_control_regs.sv ----
`timescale 1ns/1ps
module ramp_waveform_control_regs (
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  // Serial interface pins
  input  wire logic   serial_clock_pin_in,
  input  wire logic   serial_data_pin_in,
  input  wire logic   load_strobe_pin_in,
  // Modulation trigger pin
  input  wire logic   mod_trigger_pin_in,
  // Phase detector clock enable, one-cycle pulse
  input  wire logic   phase_detector_clock_in,
  // Synthesizer controls
  output logic        cp_three_state_out,
  output logic        counter_reset_out,
  output logic        integer_mode_out,
  output logic        cp_force_up_out,
  output logic        cp_force_down_out,
  output logic        multiplexed_output_pin_out,
  output logic        fast_lock_out,
  output logic        ramp_active_out,
  output logic [31:0] freq_offset_out,
  output logic [31:0] readback_out
);
  typedef struct packed {
    ramp_ctrl_pkg::ramp_state_t st;
    logic [11:0] pre, tmr, cnt, flc;
    logic [19:0] steps;
    logic        dir, set, trig_d, done, rbv, mux, up, dn, fl, act;
    logic [31:0] acc, freq, out, rb;
  } ramp_t;

  serial_word_if wif ();
  logic sclk_s, sdata_s, strobe_s, trig_s;
  ramp_ctrl_pkg::cfg_t cfg, next_cfg;
  ramp_t r, next_r;
  logic pend, next_pend, apply, tick;
  logic [2:0] addr;
  logic [31:0] w;

  pin_sync u_sclk (.clk_in(clk_in), .rst_in(rst_in),
    .pin_in(serial_clock_pin_in), .level_out(sclk_s));
  pin_sync u_sdata (.clk_in(clk_in), .rst_in(rst_in),
    .pin_in(serial_data_pin_in), .level_out(sdata_s));
  pin_sync u_strobe (.clk_in(clk_in), .rst_in(rst_in),
    .pin_in(load_strobe_pin_in), .level_out(strobe_s));
  pin_sync u_trig (.clk_in(clk_in), .rst_in(rst_in),
    .pin_in(mod_trigger_pin_in), .level_out(trig_s));
  serial_port u_port (.clk_in(clk_in), .rst_in(rst_in),
    .sclk_in(sclk_s), .sdata_in(sdata_s), .strobe_in(strobe_s),
    .out(wif.src));

  function automatic logic hit(input logic [11:0] c,
                               input logic [11:0] lim);
    return ({1'b0, c} + 13'h0001) >= {1'b0, lim};
  endfunction : hit

  function automatic logic [31:0] scaled(input logic [15:0] d,
                                         input logic [3:0] s);
    return {{16{d[15]}}, d} << s;
  endfunction : scaled

  assign tick = phase_detector_clock_in;
  assign w = wif.word;
  assign addr = w[2:0];
  // Word acts at once or waits for the next phase detector tick
  assign apply = (wif.load && (!cfg.sync_sel || tick)) // R03
               || (pend && tick);

  always_comb begin
    next_cfg = cfg;
    next_pend = pend;
    if (wif.load && cfg.sync_sel && !tick) begin
      next_pend = 1'b1; // R03
    end else if (tick) begin
      next_pend = 1'b0;
    end
    if (apply) begin
      unique case (addr) // R02
        ramp_ctrl_pkg::ADDR_FUNC: begin
          next_cfg.cp3 = w[ramp_ctrl_pkg::FN_TRI]; // R01
          next_cfg.crst = w[ramp_ctrl_pkg::FN_CRST]; // R01
        end
        ramp_ctrl_pkg::ADDR_CLK: begin
          next_cfg.sync_sel = w[ramp_ctrl_pkg::CK_SYNC]; // R03
          next_cfg.sd_mode = w[30:26]; // R04
          next_cfg.status = w[25:21]; // R05
          next_cfg.cdm = w[20:19]; // R07
          if (w[ramp_ctrl_pkg::CK_SEL]) begin
            next_cfg.clk2 = w[18:7]; // R09
          end else begin
            next_cfg.clk1 = w[18:7]; // R09
          end
        end
        ramp_ctrl_pkg::ADDR_DEV: begin
          next_cfg.dvf = w[30:24];
          if (w[ramp_ctrl_pkg::SEL_BIT]) begin
            next_cfg.sh1 = w[22:19]; // R15
            next_cfg.dev1 = w[18:3];
          end else begin
            next_cfg.sh0 = w[22:19]; // R15
            next_cfg.dev0 = w[18:3];
          end
        end
        ramp_ctrl_pkg::ADDR_STEP: begin
          if (w[ramp_ctrl_pkg::SEL_BIT]) begin
            next_cfg.st1 = w[22:3]; // R16
          end else begin
            next_cfg.st0 = w[22:3]; // R16
          end
        end
        ramp_ctrl_pkg::ADDR_DLY: next_cfg.dly = w[23:3];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg <= ramp_ctrl_pkg::CFG_RST;
      pend <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pend <= next_pend;
    end
  end

  logic int_mode, trig_en, tri_wave, pre_tick, tmr_tick, step_en;
  logic dly_tick, act_edge, rise, run_ok, last;
  logic [19:0] lim;
  logic [31:0] dv, acc_n, fsk;

  always_comb begin
    int_mode = cfg.sd_mode == ramp_ctrl_pkg::SD_INTEGER; // R04
    trig_en = cfg.dly[ramp_ctrl_pkg::DL_TRIG_EN];
    tri_wave = cfg.dly[ramp_ctrl_pkg::DL_FAST] // R20
             || cfg.dly[ramp_ctrl_pkg::DL_SINGLE]; // R18
    rise = trig_s && !r.trig_d;
    act_edge = cfg.dvf[ramp_ctrl_pkg::DV_INV] ? (!trig_s && r.trig_d)
             : rise; // R10
    pre_tick = tick && hit(r.pre, cfg.clk1);
    tmr_tick = pre_tick && hit(r.tmr, cfg.clk2); // R08
    step_en = cfg.dvf[ramp_ctrl_pkg::DV_TXCLK] ? act_edge // R11
            : (tmr_tick && cfg.cdm == ramp_ctrl_pkg::CDM_RAMP); // R07
    dly_tick = cfg.dly[ramp_ctrl_pkg::DL_CLKSEL] ? pre_tick : tick; // R22
    run_ok = !int_mode && (cfg.cdm == ramp_ctrl_pkg::CDM_RAMP
             || cfg.dvf[ramp_ctrl_pkg::DV_TXCLK]);
    lim = (r.set || (r.dir && cfg.dly[ramp_ctrl_pkg::DL_FAST]))
        ? cfg.st1 : cfg.st0;
    last = ({1'b0, r.steps} + 21'h000001) >= {1'b0, lim}; // R16
    dv = r.set ? scaled(cfg.dev1, cfg.sh1) : scaled(cfg.dev0, cfg.sh0);
    acc_n = cfg.dvf[ramp_ctrl_pkg::DV_PARAB] ? r.acc + dv : dv; // R12
    fsk = (cfg.dvf[ramp_ctrl_pkg::DV_FSKR] && trig_s) // R14
        ? scaled(cfg.dev0, cfg.sh0) : 32'h0000_0000;
  end

  always_comb begin
    next_r = r;
    next_r.trig_d = trig_s;
    next_r.done = 1'b0;
    if (tick) begin
      next_r.pre = pre_tick ? 12'h000 : r.pre + 12'h001;
    end
    if (pre_tick) begin
      next_r.tmr = tmr_tick ? 12'h000 : r.tmr + 12'h001;
    end
    if (apply && cfg.cdm == ramp_ctrl_pkg::CDM_FL) begin
      next_r.flc = cfg.clk2; // R08
    end else if (pre_tick && r.flc != 12'h000) begin
      next_r.flc = r.flc - 12'h001;
    end
    unique case (r.st)
      ramp_ctrl_pkg::IDLE: begin
        next_r.steps = 20'h00000;
        next_r.acc = 32'h0000_0000;
        next_r.freq = 32'h0000_0000;
        next_r.dir = 1'b0;
        next_r.set = 1'b0;
        next_r.cnt = 12'h000;
        if (run_ok && (!trig_en || trig_s)) begin // R19
          if (cfg.dly[ramp_ctrl_pkg::DL_DSTART] && (!trig_en
              || cfg.dly[ramp_ctrl_pkg::DL_TRIG_DLY])) begin
            next_r.st = ramp_ctrl_pkg::SDLY; // R17
          end else begin
            next_r.st = ramp_ctrl_pkg::RUN; // R17
          end
        end
      end
      ramp_ctrl_pkg::SDLY, ramp_ctrl_pkg::GAP: begin
        if (dly_tick) begin
          next_r.cnt = r.cnt + 12'h001;
          if (hit(r.cnt, cfg.dly[14:3])) begin // R22
            next_r.cnt = 12'h000;
            next_r.st = ramp_ctrl_pkg::RUN;
          end
        end
      end
      ramp_ctrl_pkg::RUN: begin
        if (step_en) begin
          next_r.acc = acc_n;
          next_r.freq = r.dir ? r.freq - acc_n : r.freq + acc_n;
          next_r.steps = r.steps + 20'h00001;
          if (last) begin
            next_r.done = 1'b1;
            next_r.steps = 20'h00000;
            next_r.acc = 32'h0000_0000;
            if (tri_wave && !r.dir) begin
              next_r.dir = 1'b1; // R20
              if (cfg.dly[ramp_ctrl_pkg::DL_TRI_DLY]
                  && cfg.dly[ramp_ctrl_pkg::DL_RAMP_DLY]) begin
                next_r.st = ramp_ctrl_pkg::GAP; // R18
              end
            end else begin
              next_r.dir = 1'b0;
              if (!tri_wave) begin
                next_r.freq = 32'h0000_0000;
              end
              if (cfg.dvf[ramp_ctrl_pkg::DV_DUAL]) begin
                next_r.set = !r.set; // R14
              end
              if (cfg.dly[ramp_ctrl_pkg::DL_SINGLE]) begin
                next_r.st = ramp_ctrl_pkg::HOLD; // R18
              end else if (cfg.dly[ramp_ctrl_pkg::DL_RAMP_DLY]) begin
                next_r.st = ramp_ctrl_pkg::GAP; // R21
              end
            end
          end
        end
      end
      ramp_ctrl_pkg::HOLD: begin
        if (apply) begin
          next_r.st = ramp_ctrl_pkg::IDLE;
        end
      end
    endcase
    if (rise && cfg.dvf[27:26] != ramp_ctrl_pkg::IRQ_OFF
        && r.st == ramp_ctrl_pkg::RUN) begin
      next_r.rb = r.freq; // R13
      next_r.rbv = 1'b1;
      if (cfg.dvf[27:26] == ramp_ctrl_pkg::IRQ_STOP) begin
        // Stop exactly at the captured frequency, even on a step cycle
        next_r.freq = r.freq; // R13
        next_r.st = ramp_ctrl_pkg::HOLD; // R13
      end
    end
    if (int_mode) begin
      next_r.st = ramp_ctrl_pkg::IDLE; // R04
    end
    next_r.out = r.freq + fsk;
    next_r.mux = (cfg.status == ramp_ctrl_pkg::ST_READBACK && r.rbv)
      || (cfg.status == ramp_ctrl_pkg::ST_DONE && r.done); // R05
    next_r.up = cfg.status == ramp_ctrl_pkg::ST_CP_UP; // R05
    next_r.dn = cfg.status == ramp_ctrl_pkg::ST_CP_DOWN;
    next_r.fl = (r.st == ramp_ctrl_pkg::GAP
      && cfg.dly[ramp_ctrl_pkg::DL_FL]) || r.flc != 12'h000; // R21
    next_r.act = next_r.st == ramp_ctrl_pkg::RUN;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cp_three_state_out <= 1'b0;
      counter_reset_out <= 1'b0;
      integer_mode_out <= 1'b0;
    end else begin
      cp_three_state_out <= cfg.cp3; // R01
      counter_reset_out <= cfg.crst; // R01
      integer_mode_out <= int_mode;
    end
  end

  assign cp_force_up_out = r.up;
  assign cp_force_down_out = r.dn;
  assign multiplexed_output_pin_out = r.mux;
  assign fast_lock_out = r.fl;
  assign ramp_active_out = r.act;
  assign freq_offset_out = r.out;
  assign readback_out = r.rb;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_func_write;
    apply && addr == ramp_ctrl_pkg::ADDR_FUNC;
  endsequence
  a_three_state_pin: assert property (s_func_write ##0 w[4] // R01
    |=> ##1 cp_three_state_out) else $error("three-state not applied");
  a_counter_reset: assert property (s_func_write ##0 !w[3] // R01
    |=> ##1 !counter_reset_out) else $error("counter reset stuck");
  a_sync_wait: assert property (wif.load && cfg.sync_sel && !tick // R03
    |=> pend && $stable(cfg)) else $error("strobe not retimed");
  a_clk_route: assert property (apply && addr == ramp_ctrl_pkg::ADDR_CLK
    && w[6] |=> cfg.clk2 == $past(w[18:7])) // R09
    else $error("clock divider misrouted");
  a_dev_select: assert property (apply && addr == ramp_ctrl_pkg::ADDR_DEV
    && !w[23] |=> cfg.dev0 == $past(w[18:3]) && $stable(cfg.dev1)) // R15
    else $error("deviation word misrouted");
  a_step_select: assert property (apply && addr == ramp_ctrl_pkg::ADDR_STEP
    && w[23] |=> cfg.st1 == $past(w[22:3])) // R16
    else $error("step word misrouted");
  a_integer_idle: assert property (int_mode [*2] // R04
    |-> r.st == ramp_ctrl_pkg::IDLE) else $error("ramp in integer mode");
  a_trig_gate: assert property (r.st == ramp_ctrl_pkg::IDLE && trig_en
    && !trig_s |=> r.st == ramp_ctrl_pkg::IDLE) // R19
    else $error("ramp started without trigger");
  a_force_up: assert property (cfg.status == ramp_ctrl_pkg::ST_CP_UP // R05
    [*2] |-> cp_force_up_out && !cp_force_down_out)
    else $error("pump not forced up");
  a_done_pulse: assert property (r.done && !apply && cfg.status // R05
    == ramp_ctrl_pkg::ST_DONE |=> multiplexed_output_pin_out)
    else $error("ramp complete not shown");
  a_irq_stop: assert property (rise && r.st == ramp_ctrl_pkg::RUN && !int_mode
    && cfg.dvf[27:26] == ramp_ctrl_pkg::IRQ_STOP |=> r.st == // R13
    ramp_ctrl_pkg::HOLD && readback_out == $past(r.freq))
    else $error("interrupt stop failed");
endmodule : ramp_waveform_control_regs

// ---- test/serial_host.sv ----
`timescale 1ns/1ps
module serial_host (
  // Clock
  input  wire logic clk_in,
  // Serial pins
  output logic      sclk_out,
  output logic      sdata_out,
  output logic      strobe_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    strobe_out = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_in);
  endtask : ticks

  // Serial clock rests low between words; data shows the inverse when idle
  task automatic send(input logic [31:0] w);
    ticks(1);
    for (int i = 31; i >= 0; i--) begin
      sdata_out = w[i];
      ticks(6);
      sclk_out = 1'b1;
      ticks(6);
      sclk_out = 1'b0;
    end
    ticks(2);
    strobe_out = 1'b1;
    ticks(6);
    strobe_out = 1'b0;
    sdata_out = ~w[0];
    ticks(12);
  endtask : send

  // Power-up order, select-bit registers twice, reserved bits zero
  task automatic init();
    send(32'h00000007);
    send(32'h00000006);
    send(32'h00800006);
    send(32'h00000005);
    send(32'h00800005);
    send(32'h00000004);
    send(32'h00000044);
    send(32'h00000003);
  endtask : init
endmodule : serial_host

// ---- test/ramp_waveform_control_regs_test.sv ----
`timescale 1ns/1ps
module ramp_waveform_control_regs_test;
  logic        clk_in;
  logic        rst_in;
  logic        sclk;
  logic        sdata;
  logic        strobe;
  logic        trig;
  logic        phase_detector_clock;
  logic        pfd_run;
  logic        cp3, crst, intm, up, dn, mux, fl, ra;
  logic [31:0] freq;
  logic [31:0] rdbk;
  logic [8:0]  flg;
  int          n_errors;
  int          n_checks;

  assign flg = {|freq, ra, fl, mux, dn, up, intm, crst, cp3};

  ramp_waveform_control_regs ramp_waveform_control_regs_inst (
    .clk_in(clk_in), .rst_in(rst_in),
    .serial_clock_pin_in(sclk), .serial_data_pin_in(sdata),
    .load_strobe_pin_in(strobe), .mod_trigger_pin_in(trig),
    .phase_detector_clock_in(phase_detector_clock),
    .cp_three_state_out(cp3), .counter_reset_out(crst),
    .integer_mode_out(intm), .cp_force_up_out(up),
    .cp_force_down_out(dn), .multiplexed_output_pin_out(mux),
    .fast_lock_out(fl), .ramp_active_out(ra),
    .freq_offset_out(freq), .readback_out(rdbk));

  serial_host serial_host_inst (
    .clk_in(clk_in), .sclk_out(sclk), .sdata_out(sdata),
    .strobe_out(strobe));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(negedge clk_in) phase_detector_clock <= pfd_run & ~phase_detector_clock;

  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic wait_for(input int b, input logic v);
    int i;
    n_checks++;
    for (i = 0; i < 3000 && flg[b] !== v; i++) @(negedge clk_in);
    if (i == 3000) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, flg[b], v);
      n_errors++;
      end_sim();
    end
  endtask : wait_for

  function automatic logic [31:0] ckw(logic [4:0] sd, logic [4:0] st,
                                     logic [1:0] m, logic [11:0] v,
                                     logic sel);
    return {1'b0, sd, st, m, v, sel, 3'h0, 3'h4};
  endfunction : ckw

  task automatic t_reset();
    chk(32'(flg), 32'h0);
    chk(rdbk, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_func();
    serial_host_inst.send(32'h00000013);
    chk(32'(flg[1:0]), 32'h1);
    serial_host_inst.send(32'h0000000B);
    chk(32'(flg[1:0]), 32'h2);
    serial_host_inst.send(32'h00000003);
    chk(32'(flg[1:0]), 32'h0);
    $display("function test done");
  endtask : t_func

  task automatic t_route();
    for (int c = 0; c < 3; c++) begin
      serial_host_inst.send(32'h38000000 | 32'(c));
      chk(32'(intm), 32'h0);
    end
    serial_host_inst.send(ckw(5'h0E, 5'h00, 2'h0, 12'h000, 1'b0));
    chk(32'(intm), 32'h1);
    serial_host_inst.send(ckw(5'h00, 5'h00, 2'h0, 12'h000, 1'b0));
    chk(32'(intm), 32'h0);
    $display("routing test done");
  endtask : t_route

  task automatic t_sync();
    serial_host_inst.send(32'h80000004);
    pfd_run = 1'b0;
    serial_host_inst.send(32'hB8000004);
    chk(32'(intm), 32'h0);
    pfd_run = 1'b1;
    repeat (6) @(negedge clk_in);
    chk(32'(intm), 32'h1);
    serial_host_inst.send(ckw(5'h00, 5'h00, 2'h0, 12'h000, 1'b0));
    chk(32'(intm), 32'h0);
    $display("sync test done");
  endtask : t_sync

  task automatic t_status();
    logic [4:0] st [3] = '{5'h10, 5'h11, 5'h00};
    logic [1:0] ex [3] = '{2'h1, 2'h2, 2'h0};
    for (int k = 0; k < 3; k++) begin
      serial_host_inst.send(ckw(5'h00, st[k], 2'h0, 12'h000, 1'b0));
      chk(32'(flg[4:3]), 32'(ex[k]));
    end
    $display("status test done");
  endtask : t_status

  task automatic t_ramp();
    serial_host_inst.send(32'h0010001D);
    serial_host_inst.send(32'h00000026);
    serial_host_inst.send(32'h00100007);
    serial_host_inst.send(ckw(5'h00, 5'h03, 2'h3, 12'h001, 1'b0));
    serial_host_inst.send(ckw(5'h00, 5'h03, 2'h3, 12'h001, 1'b1));
    repeat (50) @(negedge clk_in);
    chk(32'(ra), 32'h0);
    serial_host_inst.send(ckw(5'h0E, 5'h03, 2'h3, 12'h001, 1'b1));
    trig = 1'b1;
    repeat (50) @(negedge clk_in);
    chk(32'(ra), 32'h0);
    trig = 1'b0;
    serial_host_inst.send(ckw(5'h00, 5'h03, 2'h3, 12'h001, 1'b1));
    chk(32'(ra), 32'h0);
    trig = 1'b1;
    wait_for(7, 1'b1);
    wait_for(8, 1'b1);
    chk(freq, 32'h0000000C);
    wait_for(5, 1'b1);
    @(negedge clk_in);
    chk(32'(mux), 32'h0);
    trig = 1'b0;
    $display("ramp test done");
  endtask : t_ramp

  // Ramp still running: a trigger rise captures and stops the sweep
  task automatic t_irq();
    serial_host_inst.send(32'h0C10001D);
    serial_host_inst.send(ckw(5'h00, 5'h02, 2'h3, 12'h001, 1'b1));
    chk(32'(ra), 32'h1);
    trig = 1'b1;
    repeat (8) @(negedge clk_in);
    chk(32'(ra), 32'h0);
    chk(32'(mux), 32'h1);
    chk(freq, rdbk);
    chk(32'(rdbk <= 32'h24 && (rdbk % 32'h0000000C) == 32'h0), 32'h1);
    trig = 1'b0;
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_fast();
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk(32'(flg), 32'h0);
    // First word enters fast-lock mode, the second one starts the timer
    serial_host_inst.send(ckw(5'h00, 5'h00, 2'h1, 12'h100, 1'b1));
    serial_host_inst.send(ckw(5'h00, 5'h00, 2'h1, 12'h100, 1'b1));
    wait_for(6, 1'b1);
    repeat (400) @(negedge clk_in);
    chk(32'(fl), 32'h1);
    wait_for(6, 1'b0);
    $display("fast lock test done");
  endtask : t_fast

  initial begin
    rst_in = 1'b1;
    trig = 1'b0;
    phase_detector_clock = 1'b0;
    pfd_run = 1'b1;
    n_errors = 0;
    n_checks = 0;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge clk_in);
    t_reset();
    serial_host_inst.init();
    t_func();
    t_route();
    t_sync();
    t_status();
    t_ramp();
    t_irq();
    t_fast();
    end_sim();
  end
endmodule : ramp_waveform_control_regs_test
